// ==== inc/pbs_pkg.sv ====
// Operation
// [RULE1] register inputs and outputs; qualify holds state
// [RULE2] read starts: qualified, selected, strobe high, load
// [RULE3] read data driven one edge after request
// [RULE4] new operation accepted every cycle back to back
// [RULE5] deselect tri-states outputs after next edge
// [RULE6] output-drive low needed to see read data
// [RULE7] burst counter gives up to four accesses
// [RULE8] strap low linear, high interleaved order
// [RULE9] counter uses two low bits, wraps
// [RULE10] advance high steps counter regardless of selects
// [RULE11] direction captured at burst start, kept
// [RULE12] controller loads new address after deselect
// [RULE13] write starts: qualified, selected, strobe low
// [RULE14] lanes released the edge after write request
// [RULE15] write data captured second edge after request
// [RULE16] only selected byte lanes are stored
// [RULE17] controller avoids driving lanes while device drives
// [RULE18] drivers off during every write data phase
// [RULE19] controller drives byte selects each burst cycle
// [RULE20] interleaved order: start xor count
// [RULE21] sleep entry and exit take two cycles
// [RULE22] access pending at sleep entry is dropped
// [RULE23] controller deselects before and after sleep
// [RULE24] linear order: offset plus one modulo four
// [RULE25] reset leaves device deselected, lanes released
// [RULE26] write with no lanes selected stores nothing
// [RULE27] selects one and three low, two high
package pbs_pkg;
  localparam int ADDR_W_DEF   = 8;
  localparam int LANES_DEF    = 4;
  localparam int LANE_W       = 9;
  localparam int BURST_LEN    = 4;
  localparam int SLEEP_CYC    = 2;
  localparam int FIFO_DEPTH   = 16;
  localparam logic [1:0] OFS_RST = 2'h0;
endpackage : pbs_pkg

// ==== hw/pbs_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbs_sync3 (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // level in and out
  input  wire logic d_i,
  input  wire logic init_i,
  output logic      q_o
);
  logic s1_r, s2_r, s3_r, q_r;
  logic q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (s2_r == s3_r) begin
      q_nxt = s3_r;
    end
  end

  always_ff @(posedge clk_i) begin
    // init_i is the level assumed before the pin has been seen
    if (srst_i) begin
      s1_r <= init_i;
      s2_r <= init_i;
      s3_r <= init_i;
      q_r  <= init_i;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule // pbs_sync3
`default_nettype wire

// ==== hw/pbs_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule // pbs_fifo
`default_nettype wire

// ==== hw/pbs_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbs_port #(
  parameter int ADDR_W = pbs_pkg::ADDR_W_DEF,
  parameter int LANES  = pbs_pkg::LANES_DEF
) (
  // clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            srst_i,
  // synchronous control
  input  wire logic                            cycle_qualify_n_i,
  input  wire logic                            select_first_n_i,
  input  wire logic                            select_second_i,
  input  wire logic                            select_third_n_i,
  input  wire logic                            advance_or_load_n_i,
  input  wire logic                            write_n_i,
  input  wire logic [LANES-1:0]                byte_lane_write_n_i,
  input  wire logic [ADDR_W-1:0]               addr_i,
  // asynchronous pins
  input  wire logic                            output_drive_n_i,
  input  wire logic                            sleep_request_i,
  input  wire logic                            burst_order_i,
  // shared data and parity lanes, split
  input  wire logic [LANES*pbs_pkg::LANE_W-1:0] data_i,
  output logic [LANES*pbs_pkg::LANE_W-1:0]     data_o,
  output logic [LANES-1:0]                     data_oe_n_o,
  // status
  output logic                                 sleeping_o
);
  localparam int DW = LANES * pbs_pkg::LANE_W;
  localparam int WW = ADDR_W + LANES;

  typedef enum logic [1:0] {
    PBS_AWAKE    = 2'b00,
    PBS_ENTERING = 2'b01,
    PBS_ASLEEP   = 2'b11,
    PBS_LEAVING  = 2'b10
  } pbs_sleep_t;

  logic [DW-1:0]     mem_r [2**ADDR_W];
  logic              sleep_sync, strap_sync, odrv_n_sync;
  pbs_sleep_t        slp_r, slp_nxt;
  logic [0:0]        scnt_r, scnt_nxt;
  logic              run;

  // stage 1: address phase
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [1:0]        start_r, start_nxt;
  logic [1:0]        cnt_r, cnt_nxt;
  logic              dir_wr_r, dir_wr_nxt;
  logic              act_r, act_nxt;
  // stage 2: data phase
  logic              rd2_r, rd2_nxt, wr2_r, wr2_nxt;
  logic [ADDR_W-1:0] a2_r, a2_nxt;
  logic [LANES-1:0]  be2_r, be2_nxt;
  // stage 3: write data phase
  logic              wr3_r, wr3_nxt;
  logic [ADDR_W-1:0] a3_r, a3_nxt;
  logic [LANES-1:0]  be3_r, be3_nxt;
  // output
  logic [DW-1:0]     q_r, q_nxt;
  logic              qv_r, qv_nxt;
  // write buffer
  logic              wb_valid, wb_ready, wb_out_valid;
  logic [WW-1:0]     wb_out;

  function automatic logic [1:0] pbs_ofs(input logic [1:0] s, input logic [1:0] c,
                                         input logic il);
    pbs_ofs = il ? (s ^ c) : (s + c); // RULE20 RULE24
  endfunction

  pbs_sync3 u_sleep (.clk_i(clk_i), .srst_i(srst_i), .d_i(sleep_request_i),
                     .init_i(1'b0), .q_o(sleep_sync));
  // floating strap reads as interleaved order
  pbs_sync3 u_strap (.clk_i(clk_i), .srst_i(srst_i), .d_i(burst_order_i),
                     .init_i(1'b1), .q_o(strap_sync));
  // lanes stay released until the output-drive pin has been seen
  pbs_sync3 u_odrv  (.clk_i(clk_i), .srst_i(srst_i), .d_i(output_drive_n_i),
                     .init_i(1'b1), .q_o(odrv_n_sync));

  logic sel_all, qual, load_op, adv_op, new_rd, new_wr;
  assign sel_all = ~select_first_n_i & select_second_i & ~select_third_n_i; // RULE27
  assign run     = (slp_r == PBS_AWAKE);
  assign qual    = ~cycle_qualify_n_i & run; // RULE1
  assign load_op = qual & ~advance_or_load_n_i;
  assign adv_op  = qual & advance_or_load_n_i; // RULE10
  assign new_rd  = load_op & sel_all & write_n_i; // RULE2
  assign new_wr  = load_op & sel_all & ~write_n_i; // RULE13

  // sleep sequencing
  always_comb begin
    slp_nxt  = slp_r;
    scnt_nxt = scnt_r;
    unique case (slp_r)
      PBS_AWAKE: if (sleep_sync) begin
        slp_nxt  = PBS_ENTERING;
        scnt_nxt = 1'b0;
      end
      PBS_ENTERING: begin
        scnt_nxt = 1'b1;
        if (scnt_r == 1'b1) slp_nxt = PBS_ASLEEP; // RULE21
      end
      PBS_ASLEEP: if (!sleep_sync) begin
        slp_nxt  = PBS_LEAVING;
        scnt_nxt = 1'b0;
      end
      PBS_LEAVING: begin
        scnt_nxt = 1'b1;
        if (scnt_r == 1'b1) slp_nxt = PBS_AWAKE; // RULE21
      end
    endcase
  end

  // address phase and burst counter
  always_comb begin
    base_nxt   = base_r;
    start_nxt  = start_r;
    cnt_nxt    = cnt_r;
    dir_wr_nxt = dir_wr_r;
    act_nxt    = act_r;
    if (!run) begin
      act_nxt = 1'b0; // RULE22
    end else if (load_op) begin
      act_nxt = sel_all; // RULE5
      if (sel_all) begin
        base_nxt   = addr_i;
        start_nxt  = addr_i[1:0];
        cnt_nxt    = 2'h0;
        dir_wr_nxt = ~write_n_i; // RULE11
      end
    end else if (adv_op) begin
      cnt_nxt = cnt_r + 2'h1; // RULE7 RULE9
    end
  end

  logic [ADDR_W-1:0] cur_addr;
  assign cur_addr = {base_r[ADDR_W-1:2], pbs_ofs(start_r, cnt_nxt, strap_sync)}; // RULE8

  // data phase pipeline: one stage after address
  always_comb begin
    rd2_nxt = rd2_r;
    wr2_nxt = wr2_r;
    a2_nxt  = a2_r;
    be2_nxt = be2_r;
    if (!run) begin
      rd2_nxt = 1'b0;
      wr2_nxt = 1'b0;
    end else if (qual) begin
      rd2_nxt = new_rd | (adv_op & act_r & ~dir_wr_r); // RULE4
      wr2_nxt = new_wr | (adv_op & act_r & dir_wr_r);
      a2_nxt  = new_rd | new_wr ? addr_i : cur_addr;
      be2_nxt = ~byte_lane_write_n_i;
    end
  end

  // write data phase: lanes are taken one qualified edge after stage 3 loads
  always_comb begin
    wr3_nxt = wr3_r;
    a3_nxt  = a3_r;
    be3_nxt = be3_r;
    if (!run) begin
      wr3_nxt = 1'b0;
    end else if (qual) begin
      wr3_nxt = wr2_r;
      a3_nxt  = a2_r;
      be3_nxt = be2_r;
    end
  end

  assign wb_valid = qual & wr3_r & (|be3_r); // RULE15 RULE26

  pbs_fifo #(.WIDTH(WW), .DEPTH(pbs_pkg::FIFO_DEPTH)) u_wbuf (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (wb_valid),
    .in_ready_o  (wb_ready),
    .in_data_i   ({a3_r, be3_r}),
    .out_valid_o (wb_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (wb_out)
  );

  // write data captured separately; buffer holds address and lanes
  logic [DW-1:0] wd_r [pbs_pkg::FIFO_DEPTH];
  logic [3:0]    wdw_r, wdr_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wdw_r <= 4'h0;
      wdr_r <= 4'h0;
    end else begin
      if (wb_valid & wb_ready) wdw_r <= wdw_r + 4'h1;
      if (wb_out_valid) wdr_r <= wdr_r + 4'h1;
    end
    if (wb_valid & wb_ready) wd_r[wdw_r] <= data_i;
  end

  always_ff @(posedge clk_i) begin
    if (wb_out_valid) begin
      for (int i = 0; i < LANES; i++) begin
        if (wb_out[i]) begin
          mem_r[wb_out[WW-1:LANES]][i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] <=
            wd_r[wdr_r][i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W]; // RULE16
        end
      end
    end
  end

  // output register
  always_comb begin
    q_nxt  = q_r;
    qv_nxt = qv_r;
    if (!run) begin
      qv_nxt = 1'b0;
    end else if (qual) begin
      qv_nxt = rd2_r;
      if (rd2_r) q_nxt = mem_r[a2_r]; // RULE3
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      slp_r    <= PBS_AWAKE;
      scnt_r   <= 1'b0;
      base_r   <= '0;
      start_r  <= pbs_pkg::OFS_RST;
      cnt_r    <= 2'h0;
      dir_wr_r <= 1'b0;
      act_r    <= 1'b0; // RULE25
      rd2_r    <= 1'b0;
      wr2_r    <= 1'b0;
      a2_r     <= '0;
      be2_r    <= '0;
      wr3_r    <= 1'b0;
      a3_r     <= '0;
      be3_r    <= '0;
      q_r      <= '0;
      qv_r     <= 1'b0;
    end else begin
      slp_r    <= slp_nxt;
      scnt_r   <= scnt_nxt;
      base_r   <= base_nxt;
      start_r  <= start_nxt;
      cnt_r    <= cnt_nxt;
      dir_wr_r <= dir_wr_nxt;
      act_r    <= act_nxt;
      rd2_r    <= rd2_nxt;
      wr2_r    <= wr2_nxt;
      a2_r     <= a2_nxt;
      be2_r    <= be2_nxt;
      wr3_r    <= wr3_nxt;
      a3_r     <= a3_nxt;
      be3_r    <= be3_nxt;
      q_r      <= q_nxt;
      qv_r     <= qv_nxt;
    end
  end

  // drive only while read data valid, output-drive low, no write phase
  logic drive;
  assign drive       = qv_r & ~odrv_n_sync & ~wr3_r; // RULE6 RULE14 RULE18
  assign data_oe_n_o = {LANES{~drive}};
  assign data_o      = q_r;
  assign sleeping_o  = (slp_r == PBS_ASLEEP);

  // request edge, then the qualified edge that moves it one stage on
  sequence s_rd_issue;
    new_rd ##1 qual;
  endsequence
  sequence s_wr_issue;
    new_wr ##1 qual;
  endsequence
  sequence s_desel_issue;
    (load_op & ~sel_all) ##1 qual;
  endsequence
  sequence s_sleep_seen;
    (slp_r == PBS_AWAKE) && sleep_sync;
  endsequence

  AST_READ_DRIVES: assert property (@(posedge clk_i) disable iff (srst_i) // RULE3
    s_rd_issue |=> qv_r) else $error("read data not valid after next edge");
  AST_WRITE_RELEASE: assert property (@(posedge clk_i) disable iff (srst_i) // RULE14
    s_wr_issue |=> &data_oe_n_o) else $error("lanes driven after write");
  AST_WR_PHASE_OFF: assert property (@(posedge clk_i) disable iff (srst_i) // RULE18
    wr3_r |-> &data_oe_n_o) else $error("driven in write phase");
  AST_DESELECT: assert property (@(posedge clk_i) disable iff (srst_i) // RULE5
    s_desel_issue |=> &data_oe_n_o) else $error("deselect left outputs on");
  AST_QUALIFY_HOLD: assert property (@(posedge clk_i) disable iff (srst_i) // RULE1
    (cycle_qualify_n_i & run) |=> $stable(cnt_r) && $stable(base_r) && $stable(q_r))
    else $error("state changed on ignored edge");
  AST_ADVANCE: assert property (@(posedge clk_i) disable iff (srst_i) // RULE10
    adv_op |=> cnt_r == $past(cnt_r) + 2'h1) else $error("counter not advanced");
  AST_DIR_KEPT: assert property (@(posedge clk_i) disable iff (srst_i) // RULE11
    adv_op |=> $stable(dir_wr_r)) else $error("direction changed in burst");
  AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (srst_i) // RULE21
    s_sleep_seen |=> ##2 slp_r == PBS_ASLEEP) else $error("sleep entry not two cycles");
  AST_SLEEP_DROP: assert property (@(posedge clk_i) disable iff (srst_i) // RULE22
    !run |=> !rd2_r && !wr2_r && !wr3_r) else $error("access survived sleep");
  AST_ILV: assert property (@(posedge clk_i) disable iff (srst_i) // RULE20
    (adv_op && act_r && strap_sync) |=> (a2_r[1:0] ^ start_r) == cnt_r)
    else $error("interleave order wrong");
  AST_LIN: assert property (@(posedge clk_i) disable iff (srst_i) // RULE24
    (adv_op && act_r && !strap_sync) |=> 2'(a2_r[1:0] - start_r) == cnt_r)
    else $error("linear order wrong");
  AST_BURST_GROUP: assert property (@(posedge clk_i) disable iff (srst_i) // RULE9
    (adv_op && act_r) |=> a2_r[ADDR_W-1:2] == base_r[ADDR_W-1:2])
    else $error("burst left its four-word group");
endmodule // pbs_port
`default_nettype wire

// ==== tb/pbs_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbs_ctrl_model #(
  parameter int ADDR_W = 8,
  parameter int LANES  = 4
) (
  // clock
  input  wire logic                             clk_i,
  // controls toward the port
  output logic                                  cycle_qualify_n_o,
  output logic                                  select_first_n_o,
  output logic                                  select_second_o,
  output logic                                  select_third_n_o,
  output logic                                  advance_or_load_n_o,
  output logic                                  write_n_o,
  output logic [LANES-1:0]                      byte_lane_write_n_o,
  output logic [ADDR_W-1:0]                     addr_o,
  output logic                                  output_drive_n_o,
  output logic                                  sleep_request_o,
  output logic                                  burst_order_o,
  // data lanes
  output logic [LANES*pbs_pkg::LANE_W-1:0]      data_o,
  input  wire logic [LANES*pbs_pkg::LANE_W-1:0] rdata_i,
  input  wire logic [LANES-1:0]                 oe_n_i
);
  localparam int DW = LANES * pbs_pkg::LANE_W;
  logic [DW-1:0]    snap_d;
  logic [LANES-1:0] snap_oe;
  initial begin
    {cycle_qualify_n_o, select_first_n_o, select_second_o, select_third_n_o} = 4'h5;
    {advance_or_load_n_o, write_n_o, output_drive_n_o} = 3'h2;
    {sleep_request_o, burst_order_o} = 2'h0;
    byte_lane_write_n_o = '1;
    addr_o = '0;
    data_o = '0;
  end
  // one bus cycle; snap shows the port state left by the previous edge
  task automatic op(input logic qn, input logic sel, input logic ld_n, input logic wn,
                    input logic [LANES-1:0] ben, input logic [ADDR_W-1:0] a,
                    input logic drv, input logic [DW-1:0] d);
    @(posedge clk_i);
    snap_d = rdata_i;
    snap_oe = oe_n_i;
    cycle_qualify_n_o   <= qn;
    select_first_n_o    <= ~sel;
    select_second_o     <= sel;
    select_third_n_o    <= ~sel;
    advance_or_load_n_o <= ld_n;
    write_n_o           <= wn;
    byte_lane_write_n_o <= ben;
    addr_o              <= a;
    // released lanes never hold the last value
    data_o              <= drv ? d : ~data_o;
  endtask
  task automatic pins(input logic odn, input logic slp, input logic ord);
    @(posedge clk_i);
    output_drive_n_o <= odn;
    sleep_request_o  <= slp;
    burst_order_o    <= ord;
  endtask
endmodule // pbs_ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int AW = 8;
  localparam int LN = 4;
  localparam int DW = LN * pbs_pkg::LANE_W;
  localparam logic [DW-1:0] D0 = 36'h9_a5c3_1e7b;
  localparam logic [DW-1:0] D1 = 36'h6_3c0f_a512;
  localparam logic [DW-1:0] BM = 36'h0_07fc_01ff;
  localparam logic [DW-1:0] BX = (36'he_eeee_eeee & BM) | (36'h1_1111_1111 & ~BM);
  logic          clk_i;
  logic          srst_i;
  logic          qn, s1n, s2, s3n, ldn, wn, odn, slp, ord, sleeping;
  logic [LN-1:0] ben, oen;
  logic [AW-1:0] addr;
  logic [DW-1:0] wd, rd;
  int            failures = 0;
  int            n_compared = 0;
  int            cyc = 0;
  pbs_port #(.ADDR_W(AW), .LANES(LN)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .cycle_qualify_n_i(qn), .select_first_n_i(s1n),
    .select_second_i(s2), .select_third_n_i(s3n), .advance_or_load_n_i(ldn),
    .write_n_i(wn), .byte_lane_write_n_i(ben), .addr_i(addr), .output_drive_n_i(odn),
    .sleep_request_i(slp), .burst_order_i(ord), .data_i(wd), .data_o(rd),
    .data_oe_n_o(oen), .sleeping_o(sleeping));
  pbs_ctrl_model #(.ADDR_W(AW), .LANES(LN)) i_ctrl (
    .clk_i(clk_i), .cycle_qualify_n_o(qn), .select_first_n_o(s1n), .select_second_o(s2),
    .select_third_n_o(s3n), .advance_or_load_n_o(ldn), .write_n_o(wn),
    .byte_lane_write_n_o(ben), .addr_o(addr), .output_drive_n_o(odn),
    .sleep_request_o(slp), .burst_order_o(ord), .data_o(wd), .rdata_i(rd), .oe_n_i(oen));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) i_ctrl.op(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b0, '0);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [LN-1:0] be, input logic [DW-1:0] d);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b0, be, a, 1'b0, '0);
    idle(1);
    i_ctrl.op(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b1, d);
    idle(2);
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b1, '1, a, 1'b0, '0);
    idle(3);
    chk("read data", exp, i_ctrl.snap_d);
    chk("read drive", '0, DW'(i_ctrl.snap_oe));
    idle(1);
    chk("deselect drive", DW'(4'hf), DW'(i_ctrl.snap_oe));
  endtask
  task automatic t_back_to_back();
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b0, '0, 8'h10, 1'b0, '0);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b0, '0, 8'h11, 1'b0, '0);
    i_ctrl.op(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b1, D0);
    i_ctrl.op(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b1, D1);
    chk("write phase drive", DW'(4'hf), DW'(i_ctrl.snap_oe));
    idle(2);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b1, '1, 8'h10, 1'b0, '0);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b1, '1, 8'h11, 1'b0, '0);
    idle(2);
    chk("first read", D0, i_ctrl.snap_d);
    idle(1);
    chk("second read", D1, i_ctrl.snap_d);
    idle(3);
  endtask
  task automatic t_byte_lanes();
    wr(8'h20, 4'h0, 36'h1_1111_1111);
    wr(8'h20, 4'ha, 36'he_eeee_eeee);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'hf, 8'h20, 1'b0, '0);
    idle(1);
    i_ctrl.op(1'b0, 1'b0, 1'b0, 1'b1, '1, '0, 1'b1, 36'h5_5555_5555);
    idle(1);
    chk("empty write drive", DW'(4'hf), DW'(i_ctrl.snap_oe));
    idle(1);
    rd_chk(8'h20, BX);
  endtask
  task automatic t_stall();
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b1, '1, 8'h10, 1'b0, '0);
    i_ctrl.op(1'b1, 1'b1, 1'b0, 1'b0, '0, 8'h20, 1'b1, '0);
    idle(2);
    chk("stalled output", DW'(4'hf), DW'(i_ctrl.snap_oe));
    idle(1);
    chk("stalled read", D0, i_ctrl.snap_d);
    idle(3);
    rd_chk(8'h20, BX);
    i_ctrl.pins(1'b1, 1'b0, 1'b0);
    idle(4);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b1, '1, 8'h20, 1'b0, '0);
    idle(3);
    chk("masked drive", DW'(4'hf), DW'(i_ctrl.snap_oe));
    i_ctrl.pins(1'b0, 1'b0, 1'b0);
    idle(4);
  endtask
  task automatic burst_rd(input logic [AW-1:0] a, input logic [DW-1:0] x [4]);
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b1, '1, a, 1'b0, '0);
    for (int k = 1; k < 8; k++) begin
      i_ctrl.op(1'b0, 1'b0, k <= 3, 1'b0, '1, 8'h00, 1'b0, '0);
      if (k >= 3 && k < 7) chk("burst beat", x[k-3], i_ctrl.snap_d);
    end
  endtask
  task automatic t_burst();
    logic [DW-1:0] e [4];
    e = '{36'h0_0000_00a1, 36'h0_0000_00b2, 36'h0_0000_00c3, 36'h0_0000_00d4};
    i_ctrl.op(1'b0, 1'b1, 1'b0, 1'b0, '0, 8'h31, 1'b0, '0);
    for (int k = 0; k < 5; k++) begin
      i_ctrl.op(1'b0, 1'b0, k < 3, 1'b1, '0, 8'hff, k > 0, e[(k+3)%4]);
    end
    idle(2);
    rd_chk(8'h30, e[3]);
    burst_rd(8'h33, '{e[2], e[3], e[0], e[1]});
    i_ctrl.pins(1'b0, 1'b0, 1'b1);
    idle(5);
    burst_rd(8'h31, '{e[0], e[3], e[2], e[1]});
  endtask
  task automatic t_sleep();
    int n;
    i_ctrl.pins(1'b0, 1'b1, 1'b1);
    idle(2);
    chk("sleep too early", '0, DW'(sleeping));
    n = 0;
    while (sleeping !== 1'b1 && n < 8) begin
      idle(1);
      n++;
    end
    chk("sleep entry", DW'(1), DW'(sleeping));
    i_ctrl.pins(1'b0, 1'b0, 1'b1);
    n = 0;
    while (sleeping !== 1'b0 && n < 8) begin
      idle(1);
      n++;
    end
    chk("sleep exit", '0, DW'(sleeping));
    idle(4);
    rd_chk(8'h11, D1);
  endtask
  initial begin
    srst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    idle(1);
    chk("reset drive", DW'(4'hf), DW'(i_ctrl.snap_oe));
    chk("reset sleep", '0, DW'(sleeping));
    idle(5);
    t_back_to_back();
    t_byte_lanes();
    t_stall();
    t_burst();
    t_sleep();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
